// ===== rtl/bit_pair_buf.sv
// Purpose: Two-entry buffer between memory fetch and serial output
// Assumes: Flush drops all held bits in one cycle
// Notes:   Ready toward the fetch side is low only when both slots hold
`timescale 1ns/100ps
`include "cfg_mem_map.svh"
module bit_pair_buf
	import cfg_mem_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic flush,
	bit_stream_if.snk in_s,
	bit_stream_if.src out_s
);
	fill_t fill_r;
	logic  slot0_r;
	logic  slot1_r;
	logic  push;
	logic  pop;

	assign in_s.ready  = (fill_r != `CFG_BUF_DEPTH);
	assign out_s.valid = (fill_r != 2'h0);
	assign out_s.data  = slot0_r;
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			fill_r <= 2'h0;
		end else if (push && !pop) begin
			fill_r <= fill_r + 2'h1;
		end else if (pop && !push) begin
			fill_r <= fill_r - 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			slot0_r <= 1'b0;
			slot1_r <= 1'b0;
		end else begin
			if (pop) begin
				slot0_r <= (fill_r == 2'h2) ? slot1_r : in_s.data;
			end else if (push && fill_r == 2'h0) begin
				slot0_r <= in_s.data;
			end
			if (push && ((fill_r == 2'h1 && !pop) || fill_r == 2'h2)) begin
				slot1_r <= in_s.data;
			end
		end
	end
endmodule // bit_pair_buf

// ===== rtl/bit_stream_if.sv
// Purpose: Valid/ready carrier for one stored bit
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/100ps
interface bit_stream_if;
	logic valid;
	logic ready;
	logic data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/cfg_mem_map.svh
// Purpose: Constants for the serial configuration memory readout
// Assumes: One bit stored per address
// Notes:   Image depth is fixed; the terminal count is its last address
`ifndef CFG_MEM_MAP_SVH
`define CFG_MEM_MAP_SVH

`define CFG_ADDR_W      13
`define CFG_DEPTH       4096
`define CFG_TERM_COUNT  13'h0fff
`define CFG_ADDR_ZERO   13'h0000
`define CFG_ADDR_ONE    13'h0001
`define CFG_POL_RESET   1'h0
`define CFG_BUF_DEPTH   2'h2

`endif

// ===== rtl/cfg_mem_pkg.sv
// Purpose: Types shared by the configuration memory readout files
// Assumes: Constants come from cfg_mem_map.svh
// Notes:   None
`include "cfg_mem_map.svh"
package cfg_mem_pkg;
	typedef logic [`CFG_ADDR_W-1:0] addr_t;
	typedef logic [1:0]             fill_t;
	typedef enum logic [1:0] {
		RD_HOLD    = 2'b00,
		RD_ACTIVE  = 2'b01,
		RD_DONE    = 2'b10,
		RD_STANDBY = 2'b11
	} rd_state_t;
endpackage

// ===== rtl/serial_config_memory_readout.sv
// Purpose: Read side of a one-time-programmable serial configuration memory
// Assumes: Pins are asynchronous to clk_sys and sampled at 100 MHz
//          config_clock high and low phases last at least 4 clk_sys cycles
// Notes:   Pins are oversampled on clk_sys; config_clock is never a clock
//          Polarity and image are written only while in standby
// Function
// - Each qualified config_clock rise advances address while both enables active.
// - After each rise the bit at the current address is presented on data.
// - Active reset/output-gate holds address at zero and floats data.
// - Reset/output-gate polarity selectable; active high unprogrammed, low preferred.
// - Polarity is set only through programming, never during reads.
// - Chip enable high resets address, floats data, enters standby.
// - Data driven only while both enables active, else floated.
// - Past terminal_count the address freezes and data stays floated.
`timescale 1ns/100ps
`include "cfg_mem_map.svh"

module serial_config_memory_readout
	import cfg_mem_pkg::*;
(
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire logic            config_clock,
	input  wire logic            chip_enable_n,
	input  wire logic            reset_gate,
	output logic                 data_out,
	output logic                 data_oe,
	output logic                 standby,
	input  wire logic            prog_we,
	input  wire cfg_mem_pkg::addr_t prog_addr,
	input  wire logic            prog_bit,
	input  wire logic            prog_pol_we,
	input  wire logic            prog_pol_low
);
	import cfg_mem_pkg::*;

	//==========================================================
	// Pin synchronisers
	logic [1:0] clk_sync_r;
	logic       clk_prev_r;
	logic [1:0] ce_sync_r;
	logic [1:0] rg_sync_r;

	// Two flops per pin; only the second one is read by logic
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_sync_r <= 2'h0;
		end else begin
			clk_sync_r <= {clk_sync_r[0], config_clock};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_prev_r <= 1'b0;
		end else begin
			clk_prev_r <= clk_sync_r[1];
		end
	end

	// Chip enable resets to its idle level so reset never starts a load
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ce_sync_r <= 2'h3;
		end else begin
			ce_sync_r <= {ce_sync_r[0], chip_enable_n};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rg_sync_r <= 2'h0;
		end else begin
			rg_sync_r <= {rg_sync_r[0], reset_gate};
		end
	end

	//==========================================================
	// Programmed storage and polarity
	logic  image [`CFG_DEPTH];
	logic  pol_low_r;
	logic  prog_ok;

	// Writes only in standby so a load in progress never sees them
	assign prog_ok = ce_sync_r[1];

	// Image is not reset; it models cells that keep their charge
	always_ff @(posedge clk_sys) begin
		if (prog_we && prog_ok) begin
			image[prog_addr[`CFG_ADDR_W-2:0]] <= prog_bit;
		end
	end

	//==========================================================
	// Reset polarity
	// Polarity falls back to active high on rst; rewrite it after each reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pol_low_r <= `CFG_POL_RESET;
		end else if (prog_pol_we && prog_ok) begin
			pol_low_r <= prog_pol_low;
		end
	end

	//==========================================================
	// Control decode
	logic      gate_active;
	logic      enabled;
	logic      clk_rise;
	rd_state_t state;

	// Polarity is resolved once here; all logic below sees active high
	assign gate_active = pol_low_r ? !rg_sync_r[1] : rg_sync_r[1];
	assign enabled     = !ce_sync_r[1] && !gate_active;
	// Only the pin edge moves the counter; no internal clocking of reads
	assign clk_rise    = clk_sync_r[1] && !clk_prev_r;

	//==========================================================
	// Address counters and fetch path
	addr_t addr_r;
	addr_t fetch_r;
	logic  past_tc;
	logic  flush;
	logic  pop;

	bit_stream_if fetch_s ();
	bit_stream_if head_s ();

	// One spare bit lets the counter step past the end and stop there
	assign past_tc = (addr_r > `CFG_TERM_COUNT);
	// Any disable drops prefetched bits, so the next load restarts at zero
	assign flush   = !enabled;
	assign pop     = enabled && clk_rise && !past_tc && head_s.valid;

	// Prefetch stops at the terminal count so the head never wraps to zero
	assign fetch_s.valid = enabled && (fetch_r <= `CFG_TERM_COUNT);
	assign fetch_s.data  = image[fetch_r[`CFG_ADDR_W-2:0]];
	assign head_s.ready  = pop;

	//==========================================================
	// Read address
	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			addr_r <= `CFG_ADDR_ZERO;
		end else if (pop) begin
			addr_r <= addr_r + `CFG_ADDR_ONE;
		end
	end

	//==========================================================
	// Prefetch address and two-bit buffer
	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			fetch_r <= `CFG_ADDR_ZERO;
		end else if (fetch_s.valid && fetch_s.ready) begin
			fetch_r <= fetch_r + `CFG_ADDR_ONE;
		end
	end

	// Two bits ahead hide the fetch latency behind each pop
	bit_pair_buf u_buf (
		.clk_sys (clk_sys),
		.rst     (rst),
		.flush   (flush),
		.in_s    (fetch_s),
		.out_s   (head_s)
	);

	//==========================================================
	// State and output pins
	// Standby wins over the gate, as chip enable floats the line regardless
	always_comb begin
		state = RD_STANDBY;
		case ({ce_sync_r[1], gate_active, past_tc})
			3'b000:  state = RD_ACTIVE;
			3'b001:  state = RD_DONE;
			3'b010:  state = RD_HOLD;
			3'b011:  state = RD_HOLD;
			default: state = RD_STANDBY;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_out <= 1'b0;
		end else begin
			// Head of buffer is the bit at addr_r, refreshed after each pop
			data_out <= head_s.data;
		end
	end

	// The line floats through data_oe alone; data_out may hold stale bits
	// Enable is registered so the pin never glitches between states
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_oe <= 1'b0;
		end else begin
			case (state)
				RD_ACTIVE:  data_oe <= head_s.valid;
				RD_DONE:    data_oe <= 1'b0;
				RD_HOLD:    data_oe <= 1'b0;
				RD_STANDBY: data_oe <= 1'b0;
				default:    data_oe <= 1'b0;
			endcase
		end
	end

	//==========================================================
	// Standby indication
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			standby <= 1'b1;
		end else begin
			standby <= (state == RD_STANDBY);
		end
	end
endmodule // serial_config_memory_readout

// ===== tb/host_model.sv
// Purpose: Loading host that clocks the memory and samples its data
// Assumes: Data line pulled up while floated
// Notes:   Samples just before each rise, so the first sample is address 0
`timescale 1ns/100ps
module host_model (
	input  wire logic clk_sys,
	input  wire logic data_out,
	input  wire logic data_oe,
	output logic      config_clock
);
	event got_ev;
	logic got_bit;
	logic got_oe;
	logic din;
	assign din = data_oe ? data_out : 1'b1;
	initial config_clock = 1'b0;
	// ====
	// Clock stands low between calls, 5 high and 8 low per pulse
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			got_oe = data_oe;
			got_bit = din;
			->got_ev;
			config_clock = 1'b1;
			repeat (5) @(posedge clk_sys);
			#1 config_clock = 1'b0;
			repeat (7) @(posedge clk_sys);
		end
		#1;
	endtask
endmodule // host_model

// ===== tb/scmr_chk.sv
// Purpose: Port checks for the configuration memory readout
// Assumes: Pins held for several clk_sys cycles between changes
// Notes:   Gate polarity is tracked from the programming strobes
`timescale 1ns/100ps
module scmr_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic config_clock,
	input wire logic chip_enable_n,
	input wire logic reset_gate,
	input wire logic data_out,
	input wire logic data_oe,
	input wire logic standby,
	input wire logic prog_pol_we,
	input wire logic prog_pol_low
);
	logic pol_low_r;
	logic gate_act;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ====
	// Polarity shadow
	always_ff @(posedge clk_sys) begin
		if (rst)
			pol_low_r <= 1'b0;
		else if (prog_pol_we && chip_enable_n)
			pol_low_r <= prog_pol_low;
	end
	assign gate_act = pol_low_r ? !reset_gate : reset_gate;
	property p_rst; $fell(rst) |-> !data_oe && standby; endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
	property p_ce_oe; chip_enable_n[*6] |-> !data_oe; endproperty
	a_ce_oe: assert property (p_ce_oe) else $error("oe in standby");
	property p_ce_sb; chip_enable_n[*5] |-> standby; endproperty
	a_ce_sb: assert property (p_ce_sb) else $error("no standby");
	property p_wake; (!chip_enable_n)[*6] |-> !standby; endproperty
	a_wake: assert property (p_wake) else $error("stuck standby");
	property p_gate; gate_act[*6] |-> !data_oe; endproperty
	a_gate: assert property (p_gate) else $error("oe while gated");
	// Data may only move after a rise, never during a long low phase
	property p_hold;
		(!config_clock && !chip_enable_n && !gate_act && data_oe)[*8]
			|-> $stable(data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_sb_oe; standby[*3] |-> !data_oe; endproperty
	a_sb_oe: assert property (p_sb_oe) else $error("oe with standby");
	property p_oe_rise; $rose(data_oe) |-> !standby && !gate_act; endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("oe rose");
	c_stream: cover property ($rose(data_oe));
	c_gate: cover property (gate_act && !chip_enable_n);
	c_sb: cover property ($rose(standby));
endmodule // scmr_chk
bind serial_config_memory_readout scmr_chk chk_u (
	.clk_sys       (clk_sys),
	.rst           (rst),
	.config_clock  (config_clock),
	.chip_enable_n (chip_enable_n),
	.reset_gate    (reset_gate),
	.data_out      (data_out),
	.data_oe       (data_oe),
	.standby       (standby),
	.prog_pol_we   (prog_pol_we),
	.prog_pol_low  (prog_pol_low)
);

// ===== tb/serial_config_memory_readout_bench.sv
// Purpose: Stream, gate, standby and polarity tests of the readout
// Assumes: Image fully programmed with random bits first
// Notes:   Queue entries are {oe, line}; a floated line reads 1
`timescale 1ns/100ps
`include "cfg_mem_map.svh"
module serial_config_memory_readout_bench;
	import cfg_mem_pkg::*;
	logic clk_sys, rst, config_clock, chip_enable_n, reset_gate;
	logic data_out, data_oe, standby, prog_we, prog_bit;
	logic prog_pol_we, prog_pol_low;
	addr_t prog_addr;
	logic img [`CFG_DEPTH];
	logic [1:0] exp_q [$];
	int error_cnt = 0;
	int n_checks = 0;
	int r;
	serial_config_memory_readout dut_u (
		.clk_sys       (clk_sys),
		.rst           (rst),
		.config_clock  (config_clock),
		.chip_enable_n (chip_enable_n),
		.reset_gate    (reset_gate),
		.data_out      (data_out),
		.data_oe       (data_oe),
		.standby       (standby),
		.prog_we       (prog_we),
		.prog_addr     (prog_addr),
		.prog_bit      (prog_bit),
		.prog_pol_we   (prog_pol_we),
		.prog_pol_low  (prog_pol_low)
	);
	host_model host_u (.clk_sys, .data_out, .data_oe, .config_clock);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string nm, input logic [1:0] e, s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", nm, e, s);
		end
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Random programming strobes, one set per cycle, then all idle
	task automatic noise(input int n);
		repeat (n) begin
			{prog_we, prog_pol_we, prog_pol_low, prog_bit} = 4'($urandom);
			prog_addr = addr_t'($urandom);
			cyc(1);
		end
		{prog_we, prog_pol_we, prog_pol_low, prog_bit} = 4'h0;
	endtask
	task automatic stream(input int n);
		for (int i = 0; i < n; i++) exp_q.push_back({1'b1, img[i]});
	endtask
	initial forever begin
		@(host_u.got_ev);
		chk("data", exp_q.pop_front(), {host_u.got_oe, host_u.got_bit});
	end
	initial begin
		#800000;
		error_cnt++;
		end_sim;
	end
	// ====
	// Main sequence
	initial begin
		rst = 1'b1;
		chip_enable_n = 1'b1;
		reset_gate = 1'b0;
		{prog_we, prog_bit, prog_pol_we, prog_pol_low} = 4'h0;
		prog_addr = '0;
		r = $urandom(22);
		cyc(5);
		rst = 1'b0;
		cyc(3);
		prog_we = 1'b1;
		for (int i = 0; i < `CFG_DEPTH; i++) begin
			img[i] = 1'($urandom);
			prog_addr = addr_t'(i);
			prog_bit = img[i];
			cyc(1);
		end
		{prog_we, prog_pol_we, prog_pol_low} = 3'h3;
		cyc(1);
		prog_pol_we = 1'b0;
		{reset_gate, chip_enable_n} = 2'h2;
		cyc(12);
		stream(3);
		host_u.pulses(3);
		reset_gate = 1'b0;
		cyc(12);
		repeat (2) exp_q.push_back(2'b01);
		host_u.pulses(2);
		reset_gate = 1'b1;
		cyc(12);
		stream(`CFG_DEPTH);
		repeat (2) exp_q.push_back(2'b01);
		// Programming strobes while loading must change nothing
		fork
			host_u.pulses(`CFG_DEPTH + 2);
			noise((`CFG_DEPTH + 2) * 13);
		join
		chip_enable_n = 1'b1;
		cyc(10);
		chk("standby", 2'b11, {standby, !data_oe});
		chip_enable_n = 1'b0;
		cyc(12);
		stream(1);
		host_u.pulses(1);
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		cyc(12);
		exp_q.push_back(2'b01);
		host_u.pulses(1);
		reset_gate = 1'b0;
		cyc(12);
		stream(1);
		host_u.pulses(1);
		cyc(2);
		chk("queue", 2'h0, 2'(exp_q.size()));
		end_sim;
	end
endmodule // serial_config_memory_readout_bench
